// ==== rtl/pmcs_defs.svh ====
// Behaviour
// - strap pin low forces auto-negotiation off whatever software wrote
// - control bit 12 written 0 disables negotiation; 1 or reset enables; strap blocks writes
// - control bit 12 reads last written value, 1 after reset
// - power-down bit powers the channel down; single channel means whole device
// - isolate bit stops MII outputs and inputs, management stays alive
// - isolate ends on write 0 or reset; bit reads 1 while isolated
// - control bit 9 written 1 restarts negotiation if enabled; self-clears, reads 0
// - auxiliary restart request acts like control bit 9, but is not locked out during soft reset
// - half duplex at reset; bit 8 written 1 with negotiation off forces full
// - collision test: TXEN raises COL within 512 bit times, drops within 4
// - control bit 7 sets collision test; 0 or reset clears; reads reflect it
// - status bit 15 reads 0, bits 14 to 11 read 1
// - status bit 6 is the only writable status bit; allows 2-bit preamble
// - status bit 5 reads 1 only once negotiation has completed
// - status bit 4 latches high on far-end fault until read
// - status bit 3 always reads 1
// - status bit 2 latches low after link failure until read
// - status bit 1 latches jabber in 10BASE-T only; clears on read or reset
// - status bit 0 always reads 1
// - upper identifier register is a read-only 16-bit OUI slice
// - control bit 15 starts a 1 us self-clearing soft reset; other control writes ignored meanwhile
// - control bit 14 sets loopback; 0 or reset clears; reads reflect it
`ifndef PMCS_DEFS_SVH
`define PMCS_DEFS_SVH
`define PMCS_REG_CONTROL 5'h00
`define PMCS_REG_STATUS 5'h01
`define PMCS_REG_ID_HIGH 5'h02
`define PMCS_CTL_SRST 15
`define PMCS_CTL_LOOP 14
`define PMCS_CTL_F100 13
`define PMCS_CTL_AUTONEG_STRAP_PIN 12
`define PMCS_CTL_PDN 11
`define PMCS_CTL_ISO 10
`define PMCS_CTL_RESTART 9
`define PMCS_CTL_FDX 8
`define PMCS_CTL_COLT 7
`define PMCS_STS_PRESUP 6
`define PMCS_STS_ABILITY 5'h0F
// arbitrary identifier value, stands in for a maker code
`define PMCS_OUI_HIGH 16'h1234
`define PMCS_OP_READ 2'h2
`define PMCS_OP_WRITE 2'h1
`define PMCS_PRE_FULL 6'h20
`define PMCS_PRE_SUPP 6'h02
`define PMCS_CLK_NS 20
`define PMCS_SRST_NS 1000
`define PMCS_SRST_CYC ((`PMCS_SRST_NS + `PMCS_CLK_NS - 1) / `PMCS_CLK_NS)
`endif

// ==== rtl/pmcs_pkg.sv ====
package pmcs_pkg;
    typedef enum logic [2:0] {
        MF_IDLE = 3'b000,
        MF_START = 3'b001,
        MF_OP = 3'b010,
        MF_ADDR = 3'b011,
        MF_TURN = 3'b100,
        MF_DATA = 3'b101
    } pmcs_frame_e;

    // line-side conditions reported by the transceiver core
    typedef struct packed {
        logic link_pass;
        logic remote_fault;
        logic jabber;
        logic an_complete;
        logic mode_10bt;
    } pmcs_line_s;

    typedef struct packed {
        pmcs_frame_e st;
        logic mdc_q;
        logic [5:0] pre_cnt;
        logic [4:0] bit_cnt;
        logic [1:0] op;
        logic [15:0] shreg;
        logic mdio_out;
        logic mdio_oe;
        logic srst;
        logic [5:0] srst_cnt;
        logic loopback;
        logic force100;
        logic an_sw;
        logic pdn;
        logic iso;
        logic fdx;
        logic colt;
        logic an_eff;
        logic an_rst;
        logic presup;
        logic ancmp;
        logic rf;
        logic lstat;
        logic jab;
        logic col;
        logic mii_en;
        logic [4:0] reg_addr;
    } pmcs_state_s;
endpackage

// ==== rtl/pmcs_regs.sv ====
`timescale 1ns/1ns
`include "pmcs_defs.svh"
module pmcs_regs
    import pmcs_pkg::*;
(
    input wire logic ref_clk_i, // 50 MHz system clock
    input wire logic rst_n_i, // async chip reset, active low
    input wire logic mdc_i, // management clock, sampled
    input wire logic mdio_i, // management data in
    output logic mdio_o, // management data out
    output logic mdio_oe_o, // high while driving mdio
    input wire logic [4:0] phy_addr_i, // this device's address
    input wire logic autoneg_strap_pin_i, // low disables negotiation
    input wire pmcs_line_s line_i, // line-side conditions
    input wire logic aux_restart_i, // auxiliary restart request pulse
    input wire logic tx_en_i, // MII transmit enable
    output logic col_o, // collision test output
    output logic mii_enable_o, // low while isolated
    output logic power_down_o, // channel and device down
    output logic loopback_o, // loopback mode
    output logic force100_o, // forced speed select
    output logic autoneg_enable_o, // effective negotiation enable
    output logic an_restart_o, // one-cycle restart pulse
    output logic full_duplex_o, // forced full duplex
    output logic soft_reset_o // soft reset in progress
);
    pmcs_state_s s;
    pmcs_state_s next_s;
    logic rise;
    logic match;
    logic rd_done;
    logic [15:0] rdata;

    assign rise = mdc_i & ~s.mdc_q;
    assign match = (s.shreg[9:5] == phy_addr_i);

    always_comb
    begin
        case (s.shreg[4:0])
            `PMCS_REG_CONTROL:
                rdata = {s.srst, s.loopback, s.force100, s.an_sw, s.pdn, s.iso,
                         1'b0, s.fdx, s.colt, 7'h00};
            `PMCS_REG_STATUS:
                rdata = {1'b0, 4'hF, 4'h0, s.presup, s.ancmp, s.rf, 1'b1, s.lstat, s.jab, 1'b1};
            `PMCS_REG_ID_HIGH:
                rdata = `PMCS_OUI_HIGH;
            default:
                rdata = 16'h0000;
        endcase
    end

    always_comb
    begin
        next_s = s;
        rd_done = 1'b0;
        next_s.mdc_q = mdc_i;
        next_s.an_rst = 1'b0;
        if (rise)
        begin
            case (s.st)
                MF_IDLE:
                begin
                    if (mdio_i)
                    begin
                        if (s.pre_cnt != `PMCS_PRE_FULL)
                        begin
                            next_s.pre_cnt = s.pre_cnt + 6'h01;
                        end
                    end
                    else if (s.pre_cnt >= (s.presup ? `PMCS_PRE_SUPP : `PMCS_PRE_FULL))
                    begin
                        next_s.st = MF_START;
                    end
                    else
                    begin
                        next_s.pre_cnt = 6'h00;
                    end
                end
                MF_START:
                begin
                    next_s.pre_cnt = 6'h00;
                    next_s.bit_cnt = 5'h00;
                    next_s.st = mdio_i ? MF_OP : MF_IDLE;
                end
                MF_OP:
                begin
                    next_s.op = {s.op[0], mdio_i};
                    next_s.bit_cnt = s.bit_cnt + 5'h01;
                    if (s.bit_cnt == 5'h01)
                    begin
                        next_s.st = MF_ADDR;
                        next_s.bit_cnt = 5'h00;
                    end
                end
                MF_ADDR:
                begin
                    next_s.shreg = {s.shreg[14:0], mdio_i};
                    next_s.bit_cnt = s.bit_cnt + 5'h01;
                    if (s.bit_cnt == 5'h09)
                    begin
                        next_s.st = MF_TURN;
                        next_s.bit_cnt = 5'h00;
                    end
                end
                MF_TURN:
                begin
                    next_s.bit_cnt = s.bit_cnt + 5'h01;
                    if (s.bit_cnt == 5'h00)
                    begin
                        // snapshot here so latches can clear safely later
                        next_s.reg_addr = s.shreg[4:0];
                        if (s.op == `PMCS_OP_READ && match)
                        begin
                            next_s.mdio_oe = 1'b1;
                            next_s.mdio_out = 1'b0;
                            next_s.shreg = rdata;
                        end
                        else
                        begin
                            next_s.shreg = {6'h00, s.shreg[9:0]};
                        end
                    end
                    else
                    begin
                        next_s.st = MF_DATA;
                        next_s.bit_cnt = 5'h00;
                        next_s.op = s.mdio_oe ? s.op : (match ? s.op : 2'h0);
                        if (s.mdio_oe)
                        begin
                            next_s.mdio_out = s.shreg[15];
                        end
                    end
                end
                MF_DATA:
                begin
                    next_s.bit_cnt = s.bit_cnt + 5'h01;
                    if (s.mdio_oe)
                    begin
                        next_s.mdio_out = s.shreg[14];
                        next_s.shreg = {s.shreg[14:0], 1'b0};
                    end
                    else
                    begin
                        next_s.shreg = {s.shreg[14:0], mdio_i};
                    end
                    if (s.bit_cnt == 5'h0F)
                    begin
                        next_s.st = MF_IDLE;
                        next_s.pre_cnt = 6'h00;
                        next_s.mdio_oe = 1'b0;
                        next_s.mdio_out = 1'b0;
                        next_s.op = 2'h0;
                    end
                end
                default:
                begin
                    next_s.st = MF_IDLE;
                    next_s.mdio_oe = 1'b0;
                end
            endcase
        end
        // commit a write; the data shift pushes the address out, so use the copy taken at the turn
        if (rise && s.st == MF_DATA && s.bit_cnt == 5'h0F && !s.mdio_oe && s.op == `PMCS_OP_WRITE)
        begin
            case (s.reg_addr)
                `PMCS_REG_CONTROL:
                begin
                    // writes locked out during soft reset
                    if (!s.srst)
                    begin
                        if (s.shreg[`PMCS_CTL_SRST - 1])
                        begin
                            next_s.srst = 1'b1;
                            next_s.srst_cnt = 6'(`PMCS_SRST_CYC);
                        end
                        next_s.loopback = s.shreg[`PMCS_CTL_LOOP - 1];
                        next_s.force100 = s.shreg[`PMCS_CTL_F100 - 1];
                        if (autoneg_strap_pin_i)
                        begin
                            next_s.an_sw = s.shreg[`PMCS_CTL_AUTONEG_STRAP_PIN - 1];
                        end
                        next_s.pdn = s.shreg[`PMCS_CTL_PDN - 1];
                        // isolate set and cleared by write
                        next_s.iso = s.shreg[`PMCS_CTL_ISO - 1];
                        if (s.shreg[`PMCS_CTL_RESTART - 1] && s.an_eff)
                        begin
                            next_s.an_rst = 1'b1;
                        end
                        // full duplex only with negotiation off
                        if (!s.shreg[`PMCS_CTL_FDX - 1])
                        begin
                            next_s.fdx = 1'b0;
                        end
                        else if (!s.an_eff)
                        begin
                            next_s.fdx = 1'b1;
                        end
                        next_s.colt = s.shreg[`PMCS_CTL_COLT - 1];
                    end
                end
                `PMCS_REG_STATUS:
                    next_s.presup = s.shreg[`PMCS_STS_PRESUP - 1];
                default:
                    next_s.presup = s.presup;
            endcase
        end
        // clear latches only once the status read ends
        rd_done = rise && s.st == MF_DATA && s.bit_cnt == 5'h0F && s.mdio_oe &&
                  s.reg_addr == `PMCS_REG_STATUS;
        // soft reset countdown returns control fields to defaults
        if (s.srst)
        begin
            next_s.srst_cnt = s.srst_cnt - 6'h01;
            next_s.loopback = 1'b0;
            next_s.force100 = 1'b0;
            next_s.an_sw = 1'b1;
            next_s.pdn = 1'b0;
            next_s.iso = 1'b0;
            next_s.fdx = 1'b0;
            next_s.colt = 1'b0;
            if (s.srst_cnt == 6'h01)
            begin
                next_s.srst = 1'b0;
            end
        end
        next_s.an_eff = autoneg_strap_pin_i & next_s.an_sw;
        if (aux_restart_i && s.an_eff)
        begin
            next_s.an_rst = 1'b1;
        end
        next_s.ancmp = line_i.an_complete;
        // far-end fault latch, event beats clear
        next_s.rf = line_i.remote_fault | (s.rf & ~rd_done);
        next_s.lstat = rd_done ? line_i.link_pass : (s.lstat & line_i.link_pass);
        next_s.jab = (line_i.jabber & line_i.mode_10bt) | (s.jab & ~rd_done);
        // one cycle is far inside both bit-time bounds
        next_s.col = s.colt & tx_en_i & ~s.iso;
        next_s.mii_en = ~next_s.iso;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // effective enable stays low until the strap is first sampled
            s <= '0;
            s.an_sw <= 1'b1;
            s.mii_en <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign mdio_o = s.mdio_out;
    assign mdio_oe_o = s.mdio_oe;
    assign col_o = s.col;
    assign mii_enable_o = s.mii_en;
    assign power_down_o = s.pdn;
    assign loopback_o = s.loopback;
    assign force100_o = s.force100;
    assign autoneg_enable_o = s.an_eff;
    assign an_restart_o = s.an_rst;
    assign full_duplex_o = s.fdx;
    assign soft_reset_o = s.srst;

    localparam int SRST_HOLD = `PMCS_SRST_CYC;

    chk_strap_an_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !autoneg_strap_pin_i |=> !autoneg_enable_o)
        else $error("negotiation enabled with strap low");
    chk_restart_needs_an: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        an_restart_o |-> $past(autoneg_enable_o))
        else $error("restart pulse while negotiation disabled");
    chk_col_rises: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s.colt && !s.iso && tx_en_i |=> col_o)
        else $error("collision output missed transmit enable");
    chk_col_drops: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !tx_en_i |=> !col_o)
        else $error("collision output held without transmit enable");
    chk_fault_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        line_i.remote_fault |=> s.rf)
        else $error("far-end fault not latched");
    chk_link_latch_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !line_i.link_pass |=> !s.lstat)
        else $error("link status high after link failure");
    chk_jabber_10bt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        line_i.jabber && line_i.mode_10bt |=> s.jab)
        else $error("jabber not latched in 10BASE-T");
    chk_srst_defaults: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s.srst |=> s.an_sw && !s.loopback && !s.iso && !s.colt)
        else $error("control fields not at defaults during soft reset");
    chk_srst_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(soft_reset_o) |-> ##[SRST_HOLD:SRST_HOLD] !soft_reset_o)
        else $error("soft reset length wrong");

    // main scenarios reached
    cov_status_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) rd_done);
    cov_soft_reset: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(soft_reset_o));
    cov_col_test: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) col_o);
    cov_an_restart: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) an_restart_o);
endmodule

// ==== verif/pmcs_mac_model.sv ====
`timescale 1ns/1ns
`include "pmcs_defs.svh"
module pmcs_mac_model
    import pmcs_pkg::*;
(
    input wire logic ref_clk_i, // pacing clock
    input wire logic mdio_i, // resolved line
    output logic mdc_o, // management clock
    output logic mdio_o, // driven value
    output logic mdio_oe_o // high while driving
);
    initial
    begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, input int pre, output logic [15:0] rd);
        logic [63:0] v;
        v = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 31 + pre; i >= 0; i--)
        begin
            @(negedge ref_clk_i);
            mdc_o = 1'b0;
            mdio_o = v[i];
            // read frames hand the line over for turnaround and data
            mdio_oe_o = !(op == `PMCS_OP_READ && i < 18);
            repeat (4) @(negedge ref_clk_i);
            if (i < 16)
                rd[i] = mdio_i;
            mdc_o = 1'b1;
            repeat (3) @(negedge ref_clk_i);
        end
        // clock stands still and line is released between frames
        @(negedge ref_clk_i);
        mdc_o = 1'b0;
        mdio_oe_o = 1'b0;
    endtask
endmodule

// ==== verif/phy_mii_control_status_regs_tb_top.sv ====
`timescale 1ns/1ns
`include "pmcs_defs.svh"
module phy_mii_control_status_regs_tb_top
    import pmcs_pkg::*;
;
    localparam logic [4:0] PA = 5'h05;
    localparam logic [4:0] CTL = `PMCS_REG_CONTROL;
    localparam logic [4:0] STS = `PMCS_REG_STATUS;
    localparam logic [4:0] IDH = `PMCS_REG_ID_HIGH;
    typedef struct packed {
        logic [15:0] wr;
        logic [15:0] rd;
        logic [5:0] outs;
    } pmcs_row_s;
    // outs: loopback, negotiation, power down, mii enable, full duplex, restart seen
    pmcs_row_s rows [7] = '{
        '{16'h4000, 16'h4000, 6'b100100},
        '{16'h0900, 16'h0900, 6'b001110},
        '{16'h0400, 16'h0400, 6'b000000},
        '{16'h2000, 16'h2000, 6'b000100},
        '{16'h0200, 16'h0000, 6'b000100},
        '{16'h1000, 16'h1000, 6'b010100},
        '{16'h1200, 16'h1000, 6'b010101}
    };
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b1;
    logic aux = 1'b0;
    logic tx_en = 1'b0;
    pmcs_line_s ln = '0;
    logic mdc, mac_out, mac_oe, dut_out, dut_oe;
    logic col, mii_en, pdn, loop, f100, an_en, an_rst, fdx, srst;
    logic [15:0] d;
    int bad_count = 0;
    int total_checks = 0;
    int restarts = 0;
    int n;
    int c;
    // pull-up holds the line high when nobody drives
    wire mdio = dut_oe ? dut_out : (mac_oe ? mac_out : 1'b1);

    pmcs_regs DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dut_out),
        .mdio_oe_o(dut_oe), .phy_addr_i(PA), .autoneg_strap_pin_i(strap), .line_i(ln), .aux_restart_i(aux),
        .tx_en_i(tx_en), .col_o(col), .mii_enable_o(mii_en), .power_down_o(pdn), .loopback_o(loop),
        .force100_o(f100), .autoneg_enable_o(an_en), .an_restart_o(an_rst), .full_duplex_o(fdx),
        .soft_reset_o(srst));
    pmcs_mac_model u_mac (.ref_clk_i(ref_clk), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(mac_out),
        .mdio_oe_o(mac_oe));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (an_rst === 1'b1)
            restarts <= restarts + 1;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] x;
        u_mac.frame(`PMCS_OP_WRITE, PA, ra, wd, 32, x);
    endtask
    task automatic rd(input logic [4:0] ra, output logic [15:0] rv);
        u_mac.frame(`PMCS_OP_READ, PA, ra, 16'h0000, 32, rv);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #1500000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        foreach (rows[k])
        begin
            n = restarts;
            wr(CTL, rows[k].wr); // reserved bits zero
            repeat (4) @(negedge ref_clk);
            check({10'h000, loop, an_en, pdn, mii_en, fdx, restarts != n}, {10'h000, rows[k].outs});
            check({15'h0000, f100}, {15'h0000, rows[k].wr[13]});
            rd(CTL, d);
            check(d & 16'hFF80, rows[k].rd);
        end
        wr(CTL, 16'h4D80);
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        check({13'h0000, an_en, mii_en, fdx}, 16'h0006);
        rd(CTL, d);
        check(d & 16'hDF80, 16'h1000);
        rd(STS, d);
        check(d & 16'hF87F, 16'h7809);
        wr(STS, 16'h0040);
        wr(IDH, 16'h0000);
        u_mac.frame(`PMCS_OP_READ, PA, STS, 16'h0000, 2, d);
        check(d & 16'hF87F, 16'h7849);
        rd(IDH, d);
        check(d, `PMCS_OUI_HIGH);
        u_mac.frame(`PMCS_OP_READ, PA + 5'h01, IDH, 16'h0000, 32, d);
        check(d, 16'hFFFF);
        ln.remote_fault = 1'b1;
        repeat (4) @(negedge ref_clk);
        ln.remote_fault = 1'b0;
        rd(STS, d);
        check(d & 16'h0010, 16'h0010);
        rd(STS, d);
        check(d & 16'h0010, 16'h0000);
        ln.link_pass = 1'b1;
        rd(STS, d);
        rd(STS, d);
        check(d & 16'h0004, 16'h0004);
        ln.link_pass = 1'b0;
        repeat (4) @(negedge ref_clk);
        ln.link_pass = 1'b1;
        rd(STS, d);
        check(d & 16'h0004, 16'h0000);
        rd(STS, d);
        check(d & 16'h0004, 16'h0004);
        for (int m = 0; m < 2; m++)
        begin
            ln.mode_10bt = m[0];
            ln.jabber = 1'b1;
            repeat (4) @(negedge ref_clk);
            ln.jabber = 1'b0;
            rd(STS, d);
            check(d & 16'h0002, {14'h0000, m[0], 1'b0});
        end
        ln.an_complete = 1'b1;
        rd(STS, d);
        check(d & 16'h0022, 16'h0020);
        strap = 1'b0;
        repeat (4) @(negedge ref_clk);
        check({15'h0000, an_en}, 16'h0000);
        wr(CTL, 16'h0000);
        strap = 1'b1;
        rd(CTL, d);
        check(d & 16'h1000, 16'h1000);
        n = restarts;
        aux = 1'b1;
        @(negedge ref_clk);
        aux = 1'b0;
        repeat (4) @(negedge ref_clk);
        check({15'h0000, restarts != n}, 16'h0001);
        // test mode set alongside loopback
        wr(CTL, 16'h5080);
        tx_en = 1'b1;
        for (c = 0; c < 260 && col !== 1'b1; c++)
            @(negedge ref_clk);
        check({15'h0000, col}, 16'h0001);
        tx_en = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({15'h0000, col}, 16'h0000);
        wr(CTL, 16'h1000);
        tx_en = 1'b1;
        repeat (300) @(negedge ref_clk);
        check({15'h0000, col}, 16'h0000);
        tx_en = 1'b0;
        wr(CTL, 16'h8000);
        for (c = 0; c < 20 && srst !== 1'b1; c++)
            @(negedge ref_clk);
        for (c = 0; c < 100 && srst === 1'b1; c++)
            @(negedge ref_clk);
        check({15'h0000, c >= 40 && c <= 55}, 16'h0001);
        rd(CTL, d);
        check(d & 16'h8000, 16'h0000);
        print_verdict();
    end
endmodule
